// ---- core/pwm_led_mode_restart_control.sv ----
// led pwm controller: serial register slave, mode and restart control, pwm timebase and output stage
`timescale 1ns/10ps

// Behaviour
// - Primary bit 7 shows restart pending; writing one clears it, zero ignored; resets zero.
// - Clock-select bit is sticky; only reset clears it; one picks the external pin.
// - Refresh rate is selected clock over 4096 times divider plus one.
// - Auto-increment bit advances the register pointer after every access.
// - Sleep bit stops the timebase; it resets to one.
// - Once the timebase stops, channel levels hold; output-enable and output register changes still move the pins.
// - Bits 3..1 enable answering the three secondary bus addresses; reset zero.
// - Bit 0 enables answering the group-call address; resets one.
// - Sleep with active channels sets restart at the end of the current pwm cycle.
// - Writing one to a set restart bit clears it; the channels resume once sleep is zero, in that write or a later one.
// - Restart clears on reset, on stop after channel writes (change timing zero), or on four-byte channel loads (change timing one).
// - Full-off shutdown before sleep leaves restart cleared.
// - Output invert flips every channel level while outputs are enabled.
// - Change-timing bit picks update at stop (zero) or at acknowledge (one).
// - Stop-timed updates cover channel registers 06h..45h, any number, any order.
// - Acknowledge-timed updates need all four bytes of a channel loaded.
// - Drive-type bit picks open-drain (zero) or totem-pole (one, default).
// - With outputs disabled: 00 low, 01 high or released, 1X released.
// - After reset every channel pin drives low; output bits 7..5 read zero.
// - Divider writes are ignored while sleep is zero.
// - Pointer wraps from 69 to 0 and from 254 to 0.
module pwm_led_mode_restart_control
    import pwm_led_pkg::*;
#(
    parameter logic [6:0] PRIMARY_BUS_ADDR = 7'h40, // arbitrary value
    parameter logic [31:0] ALT_ADDR_RESET = 32'hE0E4E8EC, // arbitrary values, group address in the top byte
    parameter logic [7:0] DIVIDER_RESET = 8'h03
) (
    input wire logic core_clk,
    input wire logic resetn,
    input wire logic ext_clk,
    input wire logic scl,
    input wire logic sda,
    output logic sda_drive_value,
    output logic sda_drive_en,
    input wire logic output_enable_n,
    output logic [CHANNELS-1:0] channel_output,
    output logic [CHANNELS-1:0] channel_output_en
);

    primary_config_t mode_control_primary;
    output_configuration_t output_config;
    logic [3:0][7:0] alt_addr;
    logic [7:0] divider;
    logic [7:0] shadow [CHAN_BYTES];
    logic [7:0] active [CHAN_BYTES];
    logic [7:0] next_shadow [CHAN_BYTES];
    logic [CHAN_BYTES-1:0] byte_hit;
    logic [BYTES_PER_CHAN-1:0] chan_written [CHANNELS];
    logic [CHANNELS-1:0] apply_chan;
    logic [CHANNELS-1:0] chan_level;
    logic [CHANNELS-1:0] full_off;
    logic [CHANNELS-1:0] next_out_value;
    logic [CHANNELS-1:0] next_out_en;
    logic pwm_dirty;
    // pin synchronisers
    logic [1:0] scl_sync;
    logic [1:0] sda_sync;
    logic [1:0] oe_sync;
    logic scl_prev;
    logic sda_prev;

    always_ff @(posedge core_clk or negedge resetn) begin
        if (!resetn) begin
            scl_sync <= 2'h3;
            sda_sync <= 2'h3;
            oe_sync <= 2'h3;
            scl_prev <= 1'b1;
            sda_prev <= 1'b1;
            sda_drive_value <= 1'b0;
        end else begin
            scl_sync <= {scl_sync[0], scl};
            sda_sync <= {sda_sync[0], sda};
            oe_sync <= {oe_sync[0], output_enable_n};
            scl_prev <= scl_sync[1];
            sda_prev <= sda_sync[1];
            sda_drive_value <= 1'b0; // open drain
        end
    end

    // bus conditions, seen only on the second synchroniser stage
    wire scl_now = scl_sync[1];
    wire sda_now = sda_sync[1];
    wire outputs_disabled = oe_sync[1];
    wire scl_rise = scl_now & ~scl_prev;
    wire scl_fall = ~scl_now & scl_prev;
    wire bus_start = scl_now & scl_prev & sda_prev & ~sda_now;
    wire bus_stop = scl_now & scl_prev & ~sda_prev & sda_now;
    // serial register slave
    bus_state_t state;
    logic [3:0] bit_cnt;
    logic [7:0] shift;
    logic [7:0] pointer;
    logic reading;
    logic master_ack;

    wire byte_full = bit_cnt == BYTE_BITS;
    wire [6:0] bus_addr = shift[7:1];
    wire addr_hit = bus_addr == PRIMARY_BUS_ADDR
        || (mode_control_primary.secondary_address_a_enable && bus_addr == alt_addr[0][7:1])
        || (mode_control_primary.secondary_address_b_enable && bus_addr == alt_addr[1][7:1])
        || (mode_control_primary.secondary_address_c_enable && bus_addr == alt_addr[2][7:1])
        || (mode_control_primary.group_call_enable && bus_addr == alt_addr[3][7:1]);
    wire rx_state = state == st_addr || state == st_ptr || state == st_wdata;
    wire ptr_stb = state == st_ptr && scl_fall && byte_full;
    wire wr_stb = state == st_wdata && scl_fall && byte_full;
    wire rd_load = scl_fall && ((state == st_ack_addr && reading) || (state == st_ack_rdata && master_ack));
    wire [7:0] wdata = shift;

    // register read selection; broadcast and unmapped pointers read zero
    wire in_chan = pointer >= REG_CHAN_FIRST && pointer <= REG_CHAN_LAST;
    wire in_alt = pointer >= REG_ALT_FIRST && pointer <= REG_ALT_LAST;
    wire in_bcast = pointer >= REG_BCAST_FIRST && pointer <= REG_BCAST_LAST;
    wire [5:0] chan_idx = 6'(pointer - REG_CHAN_FIRST);
    wire [1:0] alt_idx = 2'(pointer - REG_ALT_FIRST);
    wire [1:0] bcast_idx = 2'(pointer - REG_BCAST_FIRST);
    wire [7:0] read_data = pointer == REG_PRIMARY ? mode_control_primary :
        pointer == REG_OUTPUT ? (output_config & OUTPUT_WRITE_MASK) :
        pointer == REG_DIVIDER ? divider :
        in_alt ? alt_addr[alt_idx] :
        in_chan ? shadow[chan_idx] : BYTE_ZERO;

    // byte engine: sample on scl rise, drive on scl fall; never gated by sleep
    always_ff @(posedge core_clk or negedge resetn) begin
        if (!resetn) begin
            state <= st_idle;
            bit_cnt <= 4'h0;
            shift <= 8'h00;
            reading <= 1'b0;
            master_ack <= 1'b0;
            sda_drive_en <= 1'b0;
        end else if (bus_stop) begin
            state <= st_idle;
            sda_drive_en <= 1'b0;
        end else if (bus_start) begin
            state <= st_addr;
            bit_cnt <= 4'h0;
            sda_drive_en <= 1'b0;
        end else if (rx_state && scl_rise && !byte_full) begin
            shift <= {shift[6:0], sda_now};
            bit_cnt <= bit_cnt + 4'h1;
        end else if (state == st_rdata && scl_rise) begin
            bit_cnt <= bit_cnt + 4'h1;
        end else if (state == st_ack_rdata && scl_rise) begin
            master_ack <= ~sda_now;
        end else if (rd_load) begin
            state <= st_rdata;
            bit_cnt <= 4'h0;
            shift <= read_data;
            sda_drive_en <= ~read_data[7];
        end else if (scl_fall) begin
            unique case (state)
                st_idle: begin
                end
                st_addr: begin
                    if (byte_full) begin
                        bit_cnt <= 4'h0;
                        reading <= shift[0];
                        state <= addr_hit ? st_ack_addr : st_idle;
                        sda_drive_en <= addr_hit;
                    end
                end
                st_ptr, st_wdata: begin
                    if (byte_full) begin
                        bit_cnt <= 4'h0;
                        state <= state == st_ptr ? st_ack_ptr : st_ack_wdata;
                        sda_drive_en <= 1'b1;
                    end
                end
                st_ack_addr, st_ack_ptr, st_ack_wdata: begin
                    state <= state == st_ack_addr ? st_ptr : st_wdata;
                    sda_drive_en <= 1'b0;
                end
                st_rdata: begin
                    if (byte_full) begin
                        state <= st_ack_rdata;
                        sda_drive_en <= 1'b0;
                    end else begin
                        shift <= {shift[6:0], 1'b0};
                        sda_drive_en <= ~shift[6];
                    end
                end
                st_ack_rdata: begin
                    state <= st_idle; // a not-acknowledged read ends the transfer
                end
            endcase
        end
    end

    // register pointer, stepping after each byte when enabled
    always_ff @(posedge core_clk or negedge resetn) begin
        if (!resetn) begin
            pointer <= REG_PRIMARY;
        end else if (ptr_stb) begin
            pointer <= wdata;
        end else if ((wr_stb || rd_load) && mode_control_primary.auto_increment) begin
            pointer <= advance_pointer(pointer);
        end
    end
    // external clock domain
    logic [EXT_CNT_W-1:0] ext_bin;
    logic [EXT_CNT_W-1:0] ext_gray;
    logic [EXT_CNT_W-1:0] gray_sync [2];
    logic [EXT_CNT_W-1:0] gray_bin;
    logic [EXT_CNT_W-1:0] ext_taken;

    // gray count of external edges so the word crosses safely
    always_ff @(posedge ext_clk or negedge resetn) begin
        if (!resetn) begin
            ext_bin <= '0;
            ext_gray <= '0;
        end else begin
            ext_bin <= ext_bin + 1'b1;
            ext_gray <= ext_bin ^ (ext_bin >> 1);
        end
    end

    always_ff @(posedge core_clk or negedge resetn) begin
        if (!resetn) begin
            gray_sync[0] <= '0;
            gray_sync[1] <= '0;
        end else begin
            gray_sync[0] <= ext_gray;
            gray_sync[1] <= gray_sync[0];
        end
    end

    assign gray_bin[EXT_CNT_W-1] = gray_sync[1][EXT_CNT_W-1];
    for (genvar b = 0; b < EXT_CNT_W - 1; b++) begin : g_gray
        assign gray_bin[b] = gray_bin[b+1] ^ gray_sync[1][b];
    end

    // one external edge taken per core cycle; faster external clocks are not followed
    wire ext_pending = gray_bin != ext_taken;
    always_ff @(posedge core_clk or negedge resetn) begin
        if (!resetn) begin
            ext_taken <= '0;
        end else if (ext_pending) begin
            ext_taken <= ext_taken + 1'b1;
        end
    end
    // pwm timebase and restart control
    logic [7:0] presc_cnt;
    logic [11:0] pwm_cnt;
    logic pwm_run;

    wire any_active = ~&full_off;
    wire tick = pwm_run && (mode_control_primary.external_clock_select ? ext_pending : 1'b1);
    wire presc_wrap = presc_cnt == divider;
    wire cycle_end = tick && presc_wrap && pwm_cnt == PWM_LAST;
    wire restart_set = mode_control_primary.sleep && pwm_run && cycle_end && any_active;
    wire next_run = mode_control_primary.sleep ? (pwm_run && !cycle_end && any_active)
        : !mode_control_primary.restart;

    always_ff @(posedge core_clk or negedge resetn) begin
        if (!resetn) begin
            presc_cnt <= 8'h00;
            pwm_cnt <= 12'h000;
            pwm_run <= 1'b0;
        end else begin
            pwm_run <= next_run;
            if (tick) begin
                presc_cnt <= presc_wrap ? 8'h00 : presc_cnt + 8'h01;
                pwm_cnt <= presc_wrap ? pwm_cnt + 12'h001 : pwm_cnt;
            end
        end
    end
    // configuration registers
    wire wr_primary = wr_stb && pointer == REG_PRIMARY;
    wire apply_all = bus_stop && pwm_dirty && !output_config.output_change_timing;
    wire restart_clear = (wr_primary && wdata[7]) || apply_all || |apply_chan;

    always_ff @(posedge core_clk or negedge resetn) begin
        if (!resetn) begin
            mode_control_primary <= primary_config_t'(PRIMARY_RESET);
        end else begin
            if (wr_primary) begin
                mode_control_primary[5:0] <= wdata[5:0];
                mode_control_primary.external_clock_select <= mode_control_primary.external_clock_select
                    | wdata[6];
            end
            if (restart_set) begin
                mode_control_primary.restart <= 1'b1;
            end else if (restart_clear) begin
                mode_control_primary.restart <= 1'b0;
            end
        end
    end

    always_ff @(posedge core_clk or negedge resetn) begin
        if (!resetn) begin
            output_config <= output_configuration_t'(OUTPUT_RESET);
            alt_addr <= ALT_ADDR_RESET;
            divider <= DIVIDER_RESET;
        end else if (wr_stb) begin
            if (pointer == REG_OUTPUT) begin
                output_config <= output_configuration_t'(wdata & OUTPUT_WRITE_MASK);
            end
            if (in_alt) begin
                alt_addr[alt_idx] <= wdata;
            end
            if (pointer == REG_DIVIDER && mode_control_primary.sleep) begin
                divider <= wdata;
            end
        end
    end

    // pending stop-timed update: set by any channel write, set wins over the stop clear
    always_ff @(posedge core_clk or negedge resetn) begin
        if (!resetn) begin
            pwm_dirty <= 1'b0;
        end else if (|byte_hit) begin
            pwm_dirty <= 1'b1;
        end else if (bus_stop) begin
            pwm_dirty <= 1'b0;
        end
    end
    // channel bytes: written copy and applied copy
    for (genvar i = 0; i < CHAN_BYTES; i++) begin : g_byte
        localparam int POS = i % BYTES_PER_CHAN;
        localparam logic [7:0] MASK = (POS % 2 == 1) ? HIGH_BYTE_MASK : FULL_MASK;
        localparam logic [7:0] RESET_VAL = (POS == BYTES_PER_CHAN - 1) ? OFF_HIGH_RESET : BYTE_ZERO;
        assign byte_hit[i] = wr_stb && ((in_chan && chan_idx == 6'(i))
            || (in_bcast && bcast_idx == 2'(POS)));
        assign next_shadow[i] = byte_hit[i] ? (wdata & MASK) : shadow[i];
        always_ff @(posedge core_clk or negedge resetn) begin
            if (!resetn) begin
                shadow[i] <= RESET_VAL;
                active[i] <= RESET_VAL;
            end else begin
                shadow[i] <= next_shadow[i];
                if (apply_all || apply_chan[i / BYTES_PER_CHAN]) begin
                    active[i] <= next_shadow[i];
                end
            end
        end
    end
    // per channel compare and output stage
    for (genvar c = 0; c < CHANNELS; c++) begin : g_chan
        wire [3:0] hits = byte_hit[c*BYTES_PER_CHAN +: BYTES_PER_CHAN];
        wire [11:0] on_cnt = {active[c*4+1][3:0], active[c*4]};
        wire [11:0] off_cnt = {active[c*4+3][3:0], active[c*4+2]};
        wire full_on = active[c*4+1][FULL_BIT];
        wire in_window = on_cnt <= off_cnt ? (pwm_cnt >= on_cnt && pwm_cnt < off_cnt)
            : (pwm_cnt >= on_cnt || pwm_cnt < off_cnt);
        wire lit = chan_level[c] ^ output_config.output_invert;
        assign full_off[c] = active[c*4+3][FULL_BIT];
        assign apply_chan[c] = output_config.output_change_timing && |hits && &(chan_written[c] | hits);

        // drive when enabled; disabled-state choice otherwise
        assign next_out_value[c] = outputs_disabled ? output_config.disabled_output_state == DISABLED_HIGH
            : output_config.output_drive_type & lit;
        assign next_out_en[c] = outputs_disabled ? (output_config.disabled_output_state == DISABLED_LOW
            || (output_config.disabled_output_state == DISABLED_HIGH && output_config.output_drive_type))
            : (output_config.output_drive_type || !lit);

        always_ff @(posedge core_clk or negedge resetn) begin
            if (!resetn) begin
                chan_written[c] <= 4'h0;
                chan_level[c] <= 1'b0;
            end else begin
                chan_written[c] <= apply_chan[c] ? 4'h0
                    : chan_written[c] | (output_config.output_change_timing ? hits : 4'h0);
                if (pwm_run) begin
                    chan_level[c] <= !full_off[c] && (full_on || in_window);
                end
            end
        end
    end

    // pins start driven low so nothing lights before configuration
    always_ff @(posedge core_clk or negedge resetn) begin
        if (!resetn) begin
            channel_output <= '0;
            channel_output_en <= '1;
        end else begin
            channel_output <= next_out_value;
            channel_output_en <= next_out_en;
        end
    end

endmodule : pwm_led_mode_restart_control

// ---- core/pwm_led_pkg.sv ----
// constants, register layouts and types shared by the led pwm mode and restart control block
package pwm_led_pkg;

    // register pointer values
    localparam logic [7:0] REG_PRIMARY = 8'h00;
    localparam logic [7:0] REG_OUTPUT = 8'h01;
    localparam logic [7:0] REG_ALT_FIRST = 8'h02;
    localparam logic [7:0] REG_ALT_LAST = 8'h05;
    localparam logic [7:0] REG_CHAN_FIRST = 8'h06;
    localparam logic [7:0] REG_CHAN_LAST = 8'h45;
    localparam logic [7:0] REG_BCAST_FIRST = 8'hFA;
    localparam logic [7:0] REG_BCAST_LAST = 8'hFD;
    localparam logic [7:0] REG_DIVIDER = 8'hFE;

    // geometry
    localparam int CHANNELS = 16;
    localparam int CHAN_BYTES = 64;
    localparam int BYTES_PER_CHAN = 4;
    localparam int FULL_BIT = 4;
    localparam int EXT_CNT_W = 4;
    localparam logic [3:0] BYTE_BITS = 4'h8;
    localparam logic [11:0] PWM_LAST = 12'hFFF;

    // field layouts, reset values and write masks
    localparam logic [7:0] PRIMARY_RESET = 8'h11;
    localparam logic [7:0] OUTPUT_RESET = 8'h04;
    localparam logic [7:0] OUTPUT_WRITE_MASK = 8'h1F;
    localparam logic [7:0] HIGH_BYTE_MASK = 8'h1F;
    localparam logic [7:0] FULL_MASK = 8'hFF;
    localparam logic [7:0] OFF_HIGH_RESET = 8'h10;
    localparam logic [7:0] BYTE_ZERO = 8'h00;
    localparam logic [1:0] DISABLED_LOW = 2'h0;
    localparam logic [1:0] DISABLED_HIGH = 2'h1;

    typedef struct packed {
        logic restart;
        logic external_clock_select;
        logic auto_increment;
        logic sleep;
        logic secondary_address_a_enable;
        logic secondary_address_b_enable;
        logic secondary_address_c_enable;
        logic group_call_enable;
    } primary_config_t;

    typedef struct packed {
        logic [2:0] reserved;
        logic output_invert;
        logic output_change_timing;
        logic output_drive_type;
        logic [1:0] disabled_output_state;
    } output_configuration_t;

    typedef enum {st_idle, st_addr, st_ack_addr, st_ptr, st_ack_ptr, st_wdata, st_ack_wdata, st_rdata,
        st_ack_rdata} bus_state_t;

    // pointer step with auto-increment: wraps after the last channel byte and after the divider
    function automatic logic [7:0] advance_pointer(input logic [7:0] p);
        if (p == REG_CHAN_LAST || p >= REG_DIVIDER) begin
            return REG_PRIMARY;
        end
        return p + 8'h01;
    endfunction : advance_pointer

endpackage : pwm_led_pkg

// ---- verif/bus_master_model.sv ----
// behavioural serial bus controller facing the block's scl and sda pins
`timescale 1ns/10ps
module bus_master_model (
    input wire logic core_clk,
    input wire logic sda_drive_en,
    output logic scl,
    output logic sda
);
    logic m_sda;
    // wired-and with pull-up: high only while nobody pulls low
    assign sda = m_sda & ~sda_drive_en;
    initial begin
        scl = 1'b1;
        m_sda = 1'b1;
    end
    // six cycles keeps each scl phase above the five-cycle minimum
    task hp();
        repeat (6) @(negedge core_clk);
    endtask : hp
    task start();
        m_sda = 1'b1;
        hp();
        scl = 1'b1;
        hp();
        m_sda = 1'b0;
        hp();
        scl = 1'b0;
        hp();
    endtask : start
    task stop();
        m_sda = 1'b0;
        hp();
        scl = 1'b1;
        hp();
        m_sda = 1'b1;
        hp();
    endtask : stop
    // eight data bits then the acknowledge; data moves only while scl is low
    task xfer(input logic [7:0] d, input logic a_in, output logic [7:0] q, output logic a);
        logic [8:0] w;
        logic [8:0] r;
        w = {d, a_in};
        for (int i = 8; i >= 0; i--) begin
            m_sda = w[i];
            hp();
            scl = 1'b1;
            hp();
            r[i] = sda;
            scl = 1'b0;
        end
        hp();
        q = r[8:1];
        a = r[0];
    endtask : xfer
endmodule : bus_master_model

// ---- verif/pwm_led_mode_restart_control_asserts.sv ----
// pin-level checker of the led pwm mode and restart control block
`timescale 1ns/10ps
module pwm_led_mode_restart_checker
    import pwm_led_pkg::*;
(
    input wire logic core_clk,
    input wire logic resetn,
    input wire logic ext_clk,
    input wire logic scl,
    input wire logic sda,
    input wire logic sda_drive_value,
    input wire logic sda_drive_en,
    input wire logic output_enable_n,
    input wire logic [CHANNELS-1:0] channel_output,
    input wire logic [CHANNELS-1:0] channel_output_en
);
    default clocking @(posedge core_clk); endclocking
    default disable iff (!resetn);
    logic [3:0] scl_high_cnt;
    logic bus_seen;
    // scl high time, saturating, and first bus activity since reset
    always_ff @(posedge core_clk or negedge resetn) begin
        if (!resetn) begin
            scl_high_cnt <= 4'h0;
            bus_seen <= 1'b0;
        end else begin
            scl_high_cnt <= scl ? scl_high_cnt + {3'h0, scl_high_cnt != 4'hF} : 4'h0;
            bus_seen <= bus_seen | !scl;
        end
    end
    property p_sda_open; sda_drive_value == 1'b0; endproperty
    a_sda_open: assert property (p_sda_open) else $error("sda driven high");
    property p_reset_pins; $rose(resetn) |-> (channel_output == '0 && channel_output_en == '1) [*2]; endproperty
    a_reset_pins: assert property (p_reset_pins) else $error("pins not low after reset");
    // until the bus is used the block sleeps with defaults, so pins stay driven low
    property p_idle_low; !bus_seen |-> channel_output == '0 && channel_output_en == '1; endproperty
    a_idle_low: assert property (p_idle_low) else $error("pins moved before any access");
    property p_reset_quiet; $rose(resetn) |-> !sda_drive_en [*3]; endproperty
    a_reset_quiet: assert property (p_reset_quiet) else $error("sda pulled right after reset");
    property p_sda_low_phase; $changed(sda_drive_en) |-> !$past(scl) && !$past(scl, 2); endproperty
    a_sda_low_phase: assert property (p_sda_low_phase) else $error("sda changed near scl high");
    property p_sda_width; $rose(sda_drive_en) |-> sda_drive_en [*6]; endproperty
    a_sda_width: assert property (p_sda_width) else $error("sda pull too short");
    // sda held through a long scl high would hide a stop
    property p_idle_released; scl_high_cnt == 4'hF |-> !sda_drive_en; endproperty
    a_idle_released: assert property (p_idle_released) else $error("sda held on idle bus");
    property p_disabled_uniform;
        output_enable_n [*5] |-> channel_output_en == '0 ||
            (channel_output_en == '1 && (channel_output == '0 || channel_output == '1));
    endproperty
    a_disabled_uniform: assert property (p_disabled_uniform) else $error("disabled pins differ");
endmodule : pwm_led_mode_restart_checker

bind pwm_led_mode_restart_control pwm_led_mode_restart_checker i_pwm_led_mode_restart_checker (
    .core_clk(core_clk), .resetn(resetn), .ext_clk(ext_clk), .scl(scl), .sda(sda),
    .sda_drive_value(sda_drive_value), .sda_drive_en(sda_drive_en), .output_enable_n(output_enable_n),
    .channel_output(channel_output), .channel_output_en(channel_output_en));

// ---- verif/tb.sv ----
// self-checking bench of the led pwm mode and restart control block
`timescale 1ns/10ps
module tb
    import pwm_led_pkg::*;
;
    logic core_clk, resetn, ext_clk, scl, sda, output_enable_n, sda_drive_value, sda_drive_en;
    logic [CHANNELS-1:0] channel_output, channel_output_en;
    logic [7:0] cfg [7] = '{8'h04, 8'h05, 8'h01, 8'h06, 8'h03, 8'h00, 8'h14};
    logic [6:0] hi_exp = 7'h02;
    logic [6:0] en_exp = 7'h63;
    int n_errors = 0;
    int n_compared = 0;
    int cyc = 0;
    pwm_led_mode_restart_control i_pwm_led_mode_restart_control (.core_clk(core_clk), .resetn(resetn),
        .ext_clk(ext_clk), .scl(scl), .sda(sda), .sda_drive_value(sda_drive_value), .sda_drive_en(sda_drive_en),
        .output_enable_n(output_enable_n), .channel_output(channel_output), .channel_output_en(channel_output_en));
    bus_master_model i_bus_master_model (.core_clk(core_clk), .sda_drive_en(sda_drive_en), .scl(scl), .sda(sda));
    // clocks: the external pwm clock is free running and out of phase with the core
    initial begin
        core_clk = 1'b0;
        forever #50 core_clk = ~core_clk;
    end
    initial begin
        ext_clk = 1'b0;
        #13;
        forever #40 ext_clk = ~ext_clk;
    end
    task summarize();
        $display("compared %0d, mismatches %0d", n_compared, n_errors);
        if (n_errors == 0 && n_compared > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask : summarize
    // hang guard, two and a half times the expected run
    always @(posedge core_clk) begin
        cyc++;
        if (cyc == 80000) begin
            n_errors++;
            summarize();
        end
    end
    task chk(input string what, input logic [15:0] exp, input logic [15:0] got);
        n_compared++;
        if (got !== exp) begin
            n_errors++;
            $display("unexpected %s: expected %h, seen %h", what, exp, got);
        end
    endtask : chk
    task send(input logic [7:0] b);
        logic [7:0] q;
        logic a;
        i_bus_master_model.xfer(b, 1'b1, q, a);
        chk("write ack", 16'h0000, {15'h0000, a});
    endtask : send
    // device at bus address 40h
    task wr(input logic [7:0] ptr, input logic [7:0] d[$]);
        i_bus_master_model.start();
        send(8'h80);
        send(ptr);
        foreach (d[i]) send(d[i]);
        i_bus_master_model.stop();
    endtask : wr
    task rd(input logic [7:0] ptr, input logic [7:0] e[$]);
        logic [7:0] q;
        logic a;
        i_bus_master_model.start();
        send(8'h80);
        send(ptr);
        i_bus_master_model.start();
        send(8'h81);
        foreach (e[i]) begin
            i_bus_master_model.xfer(8'hFF, i == e.size() - 1, q, a);
            chk("read data", {8'h00, e[i]}, {8'h00, q});
        end
        i_bus_master_model.stop();
    endtask : rd
    // released pins are masked out of the level compare
    task pins(input logic [15:0] v, input logic [15:0] en);
        repeat (8) @(negedge core_clk);
        chk("channel level", v, channel_output & channel_output_en);
        chk("channel drive", en, channel_output_en);
    endtask : pins
    initial begin
        resetn = 1'b0;
        output_enable_n = 1'b0;
        repeat (12) @(negedge core_clk);
        resetn = 1'b1;
        pins(16'h0000, 16'hFFFF);
        rd(REG_PRIMARY, '{PRIMARY_RESET, PRIMARY_RESET});
        rd(REG_OUTPUT, '{OUTPUT_RESET});
        wr(REG_PRIMARY, '{8'hB1});
        wr(REG_PRIMARY, '{8'h31});
        rd(REG_PRIMARY, '{8'h31, OUTPUT_RESET});
        wr(REG_DIVIDER, '{8'h00});
        wr(REG_PRIMARY, '{8'h71});
        wr(REG_PRIMARY, '{8'h31});
        rd(REG_PRIMARY, '{8'h71});
        wr(REG_PRIMARY, '{8'h61});
        wr(REG_DIVIDER, '{8'h05});
        rd(REG_DIVIDER, '{8'h00, 8'h61});
        rd(REG_CHAN_LAST, '{8'h10, 8'h61});
        rd(8'h46, '{8'h00});
        $display("register test done");
        wr(REG_OUTPUT, '{8'hFF});
        rd(REG_OUTPUT, '{8'h1F});
        pins(16'hFFFF, 16'hFFFF);
        output_enable_n = 1'b1;
        for (int i = 0; i < 7; i++) begin
            wr(REG_OUTPUT, '{cfg[i]});
            pins({16{hi_exp[i]}}, {16{en_exp[i]}});
        end
        output_enable_n = 1'b0;
        wr(REG_OUTPUT, '{8'h00});
        pins(16'h0000, 16'hFFFF);
        wr(REG_OUTPUT, '{OUTPUT_RESET});
        $display("output stage test done");
        wr(REG_CHAN_FIRST, '{8'h00, 8'h10, 8'h00, 8'h00});
        pins(16'h0001, 16'hFFFF);
        wr(REG_PRIMARY, '{8'h71});
        repeat (4000) @(negedge core_clk);
        rd(REG_PRIMARY, '{8'hF1});
        pins(16'h0001, 16'hFFFF);
        wr(REG_PRIMARY, '{8'h61});
        rd(REG_PRIMARY, '{8'hE1});
        wr(REG_PRIMARY, '{8'hE1});
        rd(REG_PRIMARY, '{8'h61});
        wr(REG_OUTPUT, '{8'h0C});
        wr(8'h0A, '{8'h00, 8'h10, 8'h00});
        pins(16'h0001, 16'hFFFF);
        wr(8'h0D, '{8'h00});
        pins(16'h0003, 16'hFFFF);
        wr(REG_OUTPUT, '{OUTPUT_RESET});
        wr(REG_PRIMARY, '{8'h71});
        repeat (4000) @(negedge core_clk);
        rd(REG_PRIMARY, '{8'hF1});
        wr(8'h09, '{8'h00});
        rd(REG_PRIMARY, '{8'h71});
        wr(REG_PRIMARY, '{8'h61});
        wr(REG_BCAST_LAST, '{8'h10});
        pins(16'h0000, 16'hFFFF);
        wr(REG_PRIMARY, '{8'h71});
        repeat (4000) @(negedge core_clk);
        rd(REG_PRIMARY, '{8'h71});
        $display("restart test done");
        summarize();
    end
endmodule : tb
